/* File: loss_limit_cfg.svh */
// Purpose: Constants for the loss upper-limit and alternate-configuration
//          register bank.
// Assumes: 8-bit register addresses and 8-bit register data.
// Notes:   Definitions only.
//
// Behaviour
// - Power-down request acts only while the shutdown permit bit is one.
// - Shutdown permit bit reads zero after reset.
// - Inductance-only drive set: loss conversions dropped and marked invalid.
// - Inductance-only drive clear: loss and high-res inductance both run.
// - Upper loss limit equals high byte times 256 plus low byte.
// - Loss result strictly above the upper limit raises the above-limit flag.
// - Low byte write is shadowed; the high byte write commits both bytes.
// - Limit writes are taken while converting and used from then on.
// - Both upper limit bytes reset to 0x00.
`ifndef LOSS_LIMIT_CFG_SVH
`define LOSS_LIMIT_CFG_SVH

`define ADDR_ALTERNATE_CONFIGURATION      8'h05
`define ADDR_LIMIT_LOW       8'h06
`define ADDR_LIMIT_HIGH      8'h07
`define ALTERNATE_CONFIGURATION_RESET     8'h00
`define LIMIT_BYTE_RESET     8'h00
`define ALT_PERMIT_BIT       1
`define ALT_IND_ONLY_BIT     0
`define ALT_RSVD_MSB         7
`define ALT_RSVD_LSB         2
`define LIMIT_HIGH_SCALE     16'h0100
`define UNMAPPED_READ        8'h00

`endif

/* File: loss_limit_pkg.sv */
// Purpose: Types for the loss upper-limit and alternate-configuration bank.
// Assumes: Constants come from loss_limit_cfg.svh.
// Notes:   Types only.
`default_nettype none
package loss_limit_pkg;

   typedef struct packed {
      logic [5:0] reserved;
      logic       shutdownPermit;
      logic       inductanceOnly;
   } alternate_configuration_t;

   typedef struct packed {
      logic [7:0] shadowLow;
      logic [7:0] activeLow;
      logic [7:0] activeHigh;
      logic       aboveFlag;
      logic       flagUpdated;
   } limit_state_t;

   typedef struct packed {
      alternate_configuration_t altCfg;
      logic [7:0]  rdData;
      logic        rdValid;
      logic        shutdownActive;
      logic        lossDriveEnable;
      logic        highResEnable;
      logic        lossDiscarded;
      logic        aboveFlagOut;
      logic        flagUpdatedOut;
      logic [15:0] limitOut;
   } bank_state_t;

endpackage

`default_nettype wire

/* File: loss_limit_compare.sv */
// Purpose: Shadowed 16-bit upper loss limit and its per-conversion compare.
// Assumes: Write strobes and conversion strobes share the clock.
// Notes:   The compare sees the limit as it stood before a same-cycle commit.
`timescale 1ns/100ps
`default_nettype none
`include "loss_limit_cfg.svh"

module loss_limit_compare
   import loss_limit_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        writeLow,
   input  wire logic        writeHigh,
   input  wire logic [7:0]  writeData,
   input  wire logic        compareStrobe,
   input  wire logic [15:0] lossResult,
   output var  logic [7:0]  shadowLow,
   output var  logic [7:0]  activeHigh,
   output var  logic [15:0] activeLimit,
   output var  logic        aboveFlag,
   output var  logic        flagUpdated
);

   limit_state_t state_reg;
   limit_state_t state_next;
   logic [15:0]  limitValue;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      limitValue = 16'(16'(state_reg.activeHigh) * `LIMIT_HIGH_SCALE
                   + 16'(state_reg.activeLow));
      state_next = state_reg;
      state_next.flagUpdated = 1'b0;
      if (writeLow) begin
         state_next.shadowLow = writeData;
      end
      if (writeHigh) begin
         state_next.activeHigh = writeData;
         state_next.activeLow  = state_reg.shadowLow;
      end
      // A conversion finishing in the commit cycle uses the old pair.
      if (compareStrobe) begin
         state_next.aboveFlag   = (lossResult > limitValue);
         state_next.flagUpdated = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= '{shadowLow:   `LIMIT_BYTE_RESET,
                        activeLow:   `LIMIT_BYTE_RESET,
                        activeHigh:  `LIMIT_BYTE_RESET,
                        aboveFlag:   1'b0,
                        flagUpdated: 1'b0};
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   assign shadowLow   = state_reg.shadowLow;
   assign activeHigh  = state_reg.activeHigh;
   assign activeLimit = limitValue;
   assign aboveFlag   = state_reg.aboveFlag;
   assign flagUpdated = state_reg.flagUpdated;

endmodule

`default_nettype wire

/* File: loss_high_limit_and_alternate_configuration.sv */
// Purpose: Alternate-configuration register and upper loss limit bank,
//          reached through the device's internal register port.
// Assumes: Register port and conversion strobes come from logic on clk.
// Notes:   Read data appears one cycle after the read strobe.
`timescale 1ns/100ps
`default_nettype none
`include "loss_limit_cfg.svh"

module loss_high_limit_and_alternate_configuration
   import loss_limit_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic [7:0]  regAddr,
   input  wire logic [7:0]  regWrData,
   input  wire logic        regWrite,
   input  wire logic        regRead,
   output var  logic [7:0]  regRdData,
   output var  logic        regRdValid,
   input  wire logic        shutdownRequest,
   output var  logic        shutdownActive,
   input  wire logic        lossDone,
   input  wire logic [15:0] lossResult,
   output var  logic        lossDriveEnable,
   output var  logic        highResEnable,
   output var  logic        lossDiscarded,
   output var  logic        lossAboveLimitFlag,
   output var  logic        lossFlagUpdated,
   output var  logic [15:0] lossUpperLimit,
   output var  logic        shutdownPermit,
   output var  logic        inductanceOnlyDrive
);

   bank_state_t state_reg;
   bank_state_t state_next;

   logic        writeAlt;
   logic        writeLow;
   logic        writeHigh;
   logic        compareStrobe;
   logic [7:0]  limitShadowLow;
   logic [7:0]  limitActiveHigh;
   logic [15:0] limitActive;
   logic        limitAbove;
   logic        limitUpdated;

   ////////////////////////////////////////////////////////////////////////
   // Address decode of the register port.
   always_comb begin
      writeAlt  = regWrite && (regAddr == `ADDR_ALTERNATE_CONFIGURATION);
      writeLow  = regWrite && (regAddr == `ADDR_LIMIT_LOW);
      writeHigh = regWrite && (regAddr == `ADDR_LIMIT_HIGH);
   end

   // Loss conversions only count while the loss drive is on.
   always_comb begin
      compareStrobe = lossDone && !state_reg.altCfg.inductanceOnly;
   end

   ////////////////////////////////////////////////////////////////////////
   loss_limit_compare limitCompare (
      .clk           (clk),
      .arst_n        (arst_n),
      .writeLow      (writeLow),
      .writeHigh     (writeHigh),
      .writeData     (regWrData),
      .compareStrobe (compareStrobe),
      .lossResult    (lossResult),
      .shadowLow     (limitShadowLow),
      .activeHigh    (limitActiveHigh),
      .activeLimit   (limitActive),
      .aboveFlag     (limitAbove),
      .flagUpdated   (limitUpdated)
   );

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_next = state_reg;
      state_next.rdValid       = 1'b0;
      state_next.lossDiscarded = 1'b0;

      // Reserved bits are stored as written; the host keeps them zero.
      if (writeAlt) begin
         state_next.altCfg = alternate_configuration_t'(regWrData);
      end

      if (regRead) begin
         state_next.rdValid = 1'b1;
         case (regAddr)
            `ADDR_ALTERNATE_CONFIGURATION: begin
               state_next.rdData = 8'(state_reg.altCfg);
            end
            `ADDR_LIMIT_LOW: begin
               state_next.rdData = limitShadowLow;
            end
            `ADDR_LIMIT_HIGH: begin
               state_next.rdData = limitActiveHigh;
            end
            default: begin
               state_next.rdData = `UNMAPPED_READ;
            end
         endcase
      end

      // The request is ignored unless the permit bit is set.
      state_next.shutdownActive = shutdownRequest
                                  && state_next.altCfg.shutdownPermit;

      state_next.lossDriveEnable =
         !state_next.altCfg.inductanceOnly;
      state_next.highResEnable = 1'b1;

      // A loss result finishing under inductance-only drive is dropped.
      if (lossDone && state_reg.altCfg.inductanceOnly) begin
         state_next.lossDiscarded = 1'b1;
      end

      state_next.aboveFlagOut   = limitAbove;
      state_next.flagUpdatedOut = limitUpdated;
      state_next.limitOut       = limitActive;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= '{altCfg:          alternate_configuration_t'(`ALTERNATE_CONFIGURATION_RESET),
                        rdData:          8'h00,
                        rdValid:         1'b0,
                        shutdownActive:  1'b0,
                        lossDriveEnable: 1'b1,
                        highResEnable:   1'b1,
                        lossDiscarded:   1'b0,
                        aboveFlagOut:    1'b0,
                        flagUpdatedOut:  1'b0,
                        limitOut:        16'h0000};
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   assign regRdData           = state_reg.rdData;
   assign regRdValid          = state_reg.rdValid;
   assign shutdownActive      = state_reg.shutdownActive;
   assign lossDriveEnable     = state_reg.lossDriveEnable;
   assign highResEnable       = state_reg.highResEnable;
   assign lossDiscarded       = state_reg.lossDiscarded;
   assign lossAboveLimitFlag  = state_reg.aboveFlagOut;
   assign lossFlagUpdated     = state_reg.flagUpdatedOut;
   assign lossUpperLimit      = state_reg.limitOut;
   assign shutdownPermit      = state_reg.altCfg.shutdownPermit;
   assign inductanceOnlyDrive = state_reg.altCfg.inductanceOnly;

endmodule

`default_nettype wire

/* File: loss_limit_assertions.sv */
// Purpose: Port checker for the loss limit and configuration bank.
// Assumes: No register write in the cycle of a counted conversion or in the cycle after it.
// Notes:   Bound to the top module below.
`timescale 1ns/100ps
`default_nettype none
`include "loss_limit_cfg.svh"
module loss_limit_assertions (
   input wire logic        clk,
   input wire logic        arst_n,
   input wire logic        regWrite,
   input wire logic        shutdownRequest,
   input wire logic        lossDone,
   input wire logic        shutdownActive,
   input wire logic        lossDriveEnable,
   input wire logic        lossDiscarded,
   input wire logic        lossAboveLimitFlag,
   input wire logic        lossFlagUpdated,
   input wire logic        shutdownPermit,
   input wire logic        inductanceOnlyDrive,
   input wire logic [7:0]  regAddr,
   input wire logic [15:0] lossResult,
   input wire logic [15:0] lossUpperLimit
);
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   property p_gate; shutdownActive |-> shutdownPermit; endproperty
   a_gate: assert property (p_gate) else $error("shutdown no permit");
   property p_on; shutdownRequest ##1 shutdownPermit |-> shutdownActive;
   endproperty
   a_on: assert property (p_on) else $error("shutdown not entered");
   property p_rst;
      $rose(arst_n) |-> !shutdownPermit && lossUpperLimit == 16'h0000;
   endproperty
   a_rst: assert property (p_rst) else $error("bad reset value");
   property p_drv;
      $stable(inductanceOnlyDrive) |-> lossDriveEnable != inductanceOnlyDrive;
   endproperty
   a_drv: assert property (p_drv) else $error("drive mismatch");
   property p_dis; lossDiscarded == $past(lossDone && inductanceOnlyDrive);
   endproperty
   a_dis: assert property (p_dis) else $error("discard wrong");
   property p_cmp;
      lossDone && !inductanceOnlyDrive && !regWrite ##1 !regWrite |-> ##1
         lossFlagUpdated &&
         (lossAboveLimitFlag == ($past(lossResult, 2) > lossUpperLimit));
   endproperty
   a_cmp: assert property (p_cmp) else $error("compare wrong");
   property p_upd; lossFlagUpdated |-> $past(lossDone, 2); endproperty
   a_upd: assert property (p_upd) else $error("stray update");
   property p_low;
      regWrite && regAddr == `ADDR_LIMIT_LOW ##1 !regWrite |-> ##1
         $stable(lossUpperLimit);
   endproperty
   a_low: assert property (p_low) else $error("low byte leaked");
endmodule
bind loss_high_limit_and_alternate_configuration
   loss_limit_assertions loss_limit_assertions_inst (
      .clk                 (clk),
      .arst_n              (arst_n),
      .regWrite            (regWrite),
      .shutdownRequest     (shutdownRequest),
      .lossDone            (lossDone),
      .shutdownActive      (shutdownActive),
      .lossDriveEnable     (lossDriveEnable),
      .lossDiscarded       (lossDiscarded),
      .lossAboveLimitFlag  (lossAboveLimitFlag),
      .lossFlagUpdated     (lossFlagUpdated),
      .shutdownPermit      (shutdownPermit),
      .inductanceOnlyDrive (inductanceOnlyDrive),
      .regAddr             (regAddr),
      .lossResult          (lossResult),
      .lossUpperLimit      (lossUpperLimit)
   );
`default_nettype wire

/* File: loss_limit_host.sv */
// Purpose: Host model that configures the bank over the register port.
// Assumes: Calls start 1 ns after a rising clock edge.
// Notes:   Each access ends with an idle cycle, address and data inverted and both strobes low.
`timescale 1ns/100ps
`default_nettype none
`include "loss_limit_cfg.svh"
module loss_limit_host (
   input  wire logic       clk,
   input  wire logic       regRdValid,
   input  wire logic [7:0] regRdData,
   output var  logic [7:0] regAddr,
   output var  logic [7:0] regWrData,
   output var  logic       regWrite,
   output var  logic       regRead
);
   initial {regAddr, regWrData, regWrite, regRead} = 18'h00000;
   task automatic access(input logic w, input logic [7:0] a, d,
                         output logic [7:0] q);
      {regAddr, regWrData, regWrite, regRead} = {a, d, w, !w};
      @(posedge clk);
      #1 q = regRdValid ? regRdData : 8'hXX;
      {regAddr, regWrData, regWrite, regRead} = {~a, ~d, 2'b00};
      @(posedge clk);
      #1;
   endtask
   task automatic alt(input logic permit, input logic indOnly);
      logic [7:0] q;
      access(1'b1, `ADDR_ALTERNATE_CONFIGURATION, {6'h00, permit, indOnly}, q);
   endtask
   task automatic setLimit(input logic [15:0] v);
      logic [7:0] q;
      access(1'b1, `ADDR_LIMIT_LOW, v[7:0], q);
      access(1'b1, `ADDR_LIMIT_HIGH, v[15:8], q);
   endtask
endmodule
`default_nettype wire

/* File: testbench.sv */
// Purpose: Self-checking bench for the loss limit and configuration bank.
// Assumes: The host model drives the register port.
// Notes:   Inputs change 1 ns after the rising edge.
`timescale 1ns/100ps
`default_nettype none
`include "loss_limit_cfg.svh"
module testbench;
   logic        clk, arst_n, regWrite, regRead, regRdValid, shutdownRequest;
   logic        shutdownActive, lossDone, lossDriveEnable, highResEnable;
   logic        lossDiscarded, lossAboveLimitFlag, lossFlagUpdated;
   logic        shutdownPermit, inductanceOnlyDrive;
   logic [7:0]  regAddr, regWrData, regRdData, q;
   logic [15:0] lossResult, lossUpperLimit;
   int          errCount = 0, checkCount = 0;
   loss_high_limit_and_alternate_configuration loss_high_limit_and_alternate_configuration_inst (
      .clk                 (clk),
      .arst_n              (arst_n),
      .regAddr             (regAddr),
      .regWrData           (regWrData),
      .regWrite            (regWrite),
      .regRead             (regRead),
      .regRdData           (regRdData),
      .regRdValid          (regRdValid),
      .shutdownRequest     (shutdownRequest),
      .shutdownActive      (shutdownActive),
      .lossDone            (lossDone),
      .lossResult          (lossResult),
      .lossDriveEnable     (lossDriveEnable),
      .highResEnable       (highResEnable),
      .lossDiscarded       (lossDiscarded),
      .lossAboveLimitFlag  (lossAboveLimitFlag),
      .lossFlagUpdated     (lossFlagUpdated),
      .lossUpperLimit      (lossUpperLimit),
      .shutdownPermit      (shutdownPermit),
      .inductanceOnlyDrive (inductanceOnlyDrive)
   );
   loss_limit_host loss_limit_host_inst (
      .clk        (clk),
      .regRdValid (regRdValid),
      .regRdData  (regRdData),
      .regAddr    (regAddr),
      .regWrData  (regWrData),
      .regWrite   (regWrite),
      .regRead    (regRead)
   );
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic chk(input logic [15:0] seen, exp);
      checkCount++;
      if (seen !== exp) begin
         errCount++;
         $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task automatic conv(input logic [15:0] v, input logic flag, upd);
      {lossDone, lossResult} = {1'b1, v};
      @(posedge clk);
      #1 {lossDone, lossResult} = {1'b0, ~v};
      chk(lossDiscarded, !upd);
      @(posedge clk);
      #1 chk(lossFlagUpdated, upd);
      chk(lossAboveLimitFlag, flag);
   endtask
   task automatic tReset;
      chk({shutdownPermit, inductanceOnlyDrive}, 2'b00);
      chk({lossDriveEnable, highResEnable}, 2'b11);
      for (int i = 5; i < 8; i++) begin
         loss_limit_host_inst.access(1'b0, 8'(i), 8'h00, q);
         chk(q, 8'h00);
      end
   endtask
   task automatic tShutdown;
      shutdownRequest = 1'b1;
      repeat (3) @(posedge clk);
      #1 chk(shutdownActive, 1'b0);
      loss_limit_host_inst.alt(1'b1, 1'b0);
      chk(shutdownActive, 1'b1);
      loss_limit_host_inst.access(1'b0, `ADDR_ALTERNATE_CONFIGURATION, 8'h00, q);
      chk(q, 8'h02);
      loss_limit_host_inst.alt(1'b0, 1'b0);
      chk(shutdownActive, 1'b0);
      shutdownRequest = 1'b0;
   endtask
   task automatic tLimit;
      loss_limit_host_inst.access(1'b1, `ADDR_LIMIT_LOW, 8'h34, q);
      chk(lossUpperLimit, 16'h0000);
      conv(16'h0001, 1'b1, 1'b1);
      loss_limit_host_inst.access(1'b1, `ADDR_LIMIT_HIGH, 8'h12, q);
      chk(lossUpperLimit, 16'h1234);
      conv(16'h1235, 1'b1, 1'b1);
      conv(16'h1234, 1'b0, 1'b1);
      loss_limit_host_inst.setLimit(16'h00FF);
      conv(16'h0100, 1'b1, 1'b1);
   endtask
   task automatic tIndOnly;
      loss_limit_host_inst.alt(1'b0, 1'b1);
      chk({lossDriveEnable, highResEnable}, 2'b01);
      conv(16'h0000, 1'b1, 1'b0);
      loss_limit_host_inst.alt(1'b0, 1'b0);
      chk(lossDriveEnable, 1'b1);
      conv(16'h0000, 1'b0, 1'b1);
   endtask
   task automatic endOfTest;
      $display("errors %0d checks %0d", errCount, checkCount);
      if (errCount == 0 && checkCount > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      {arst_n, shutdownRequest, lossDone, lossResult} = 19'h00000;
      repeat (12) @(posedge clk);
      #1 arst_n = 1'b1;
      tReset;
      tShutdown;
      tLimit;
      tIndOnly;
      endOfTest;
   end
   // The tests need under 100 cycles; 2000 cycles means a hang.
   initial begin
      #100000 errCount++;
      endOfTest;
   end
endmodule
`default_nettype wire
